// >>> core/mag_top.sv
/*
  Circular address generator: control and boundary registers on an
  AXI4-Lite slave, and three address lanes (X read, X write, Y) fed by
  the instruction decoder. Assumes the decoder never offers a move read
  and a multiply-accumulate prefetch in the same cycle.
*/
module mag_top
  import mag_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Move and accumulator operands
  input  wire mag_req_type rd_req,
  input  wire mag_req_type wr_req,
  input  wire logic [15:0] offset_reg_val,
  // Multiply-accumulate prefetch
  input  wire mag_mac_type mac,
  // Generated addresses
  output mag_res_type      xr_res,
  output mag_res_type      xw_res,
  output mag_res_type      y_res,
  output logic             mac_err
);
  `include "mag_consts.svh"

  logic [15:0]    ctrl_r, xs_r, xe_r, ys_r, ye_r, rev_r;
  logic [7:0]     awaddr_r;
  logic [31:0]    wdata_r, rdata_r;
  logic [3:0]     wstrb_r;
  logic           aw_have_r, w_have_r, rvalid_r, mac_err_r;
  logic [1:0]     bresp_r, rresp_r;
  mag_wstate_type ws_r;
  logic           do_wr, wr_hit;
  logic           x_on, y_on, brev_en;
  mag_req_type    xr_q, xw_q, y_q, macx_q;

  // Merge enabled byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  // Substitute the shared offset register value in indexed mode
  function automatic mag_req_type fix_ofs(input mag_req_type q, input logic [15:0] ofs);
    fix_ofs = q;
    if (q.mode == MD_REGOFS) fix_ofs.modv = ofs;
  endfunction

  // Turn one multiply-accumulate operand into a lane request
  function automatic mag_req_type mac_req(input logic v, input logic [3:0] wr,
                                          input logic idx_ok, input mag_mac_mode_type m,
                                          input logic [15:0] p, input logic [15:0] ofs);
    mac_req       = '0;
    mac_req.valid = v;
    mac_req.wreg  = wr;
    mac_req.ptr   = p;
    mac_req.word  = 1'b1;
    mac_req.mode  = MD_POST;
    case (m)
      MC_IND:  mac_req.mode = MD_IND;
      MC_INC2: mac_req.modv = `MAG_STEP2;
      MC_INC4: mac_req.modv = `MAG_STEP4;
      MC_INC6: mac_req.modv = `MAG_STEP6;
      MC_DEC2: mac_req.modv = 16'h0000 - `MAG_STEP2;
      MC_DEC4: mac_req.modv = 16'h0000 - `MAG_STEP4;
      MC_DEC6: mac_req.modv = 16'h0000 - `MAG_STEP6;
      default: begin
        mac_req.mode = idx_ok ? MD_REGOFS : MD_IND;
        mac_req.modv = ofs;
      end
    endcase
  endfunction

  // Circular and bit-reverse activation
  assign x_on    = ctrl_r[`MAG_XEN] && (ctrl_r[`MAG_XSEL] != `MAG_SEL_OFF);
  assign y_on    = ctrl_r[`MAG_YEN] && (ctrl_r[`MAG_YSEL] != `MAG_SEL_OFF);
  assign brev_en = rev_r[`MAG_BITREV_ENABLE] && (ctrl_r[`MAG_BSEL] != `MAG_SEL_OFF);

  // Lane requests: W8/W9 to the X read lane, W10/W11 to the Y lane
  assign macx_q = mac_req(mac.valid, {3'b100, mac.xsel}, mac.xsel, mac.xmode, mac.xptr,
                          offset_reg_val);
  assign y_q    = mac_req(mac.valid, {3'b101, mac.ysel}, mac.ysel, mac.ymode, mac.yptr,
                          offset_reg_val);
  assign xr_q   = mac.valid ? macx_q : fix_ofs(rd_req, offset_reg_val);
  assign xw_q   = fix_ofs(wr_req, offset_reg_val);

  // X read lane
  mag_agu #(
    .BREV_OK   (1'b0),
    .WORD_ONLY (1'b0)
  ) u_x_read_addr_unit (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req       (xr_q),
    .circ_on   (x_on && (xr_q.wreg == ctrl_r[`MAG_XSEL])),
    .bnd_start (xs_r),
    .bnd_end   (xe_r),
    .brev_on   (1'b0),
    .brev_mod  (15'h0000),
    .res_r     (xr_res)
  );

  // X write lane, the only one that steps bit-reversed
  mag_agu #(
    .BREV_OK   (1'b1),
    .WORD_ONLY (1'b0)
  ) u_x_write_addr_unit (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req       (xw_q),
    .circ_on   (x_on && (xw_q.wreg == ctrl_r[`MAG_XSEL])),
    .bnd_start (xs_r),
    .bnd_end   (xe_r),
    .brev_on   (brev_en && (xw_q.wreg == ctrl_r[`MAG_BSEL])),
    .brev_mod  (rev_r[`MAG_BMOD]),
    .res_r     (xw_res)
  );

  // Y lane, word data only
  mag_agu #(
    .BREV_OK   (1'b0),
    .WORD_ONLY (1'b1)
  ) u_y_addr_unit (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req       (y_q),
    .circ_on   (y_on && (y_q.wreg == ctrl_r[`MAG_YSEL])),
    .bnd_start (ys_r),
    .bnd_end   (ye_r),
    .brev_on   (1'b0),
    .brev_mod  (15'h0000),
    .res_r     (y_res)
  );

  // Flag an indexed prefetch through W8 or W10
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_err_r <= 1'b0;
    end else if (mac.valid) begin
      mac_err_r <= (mac.xmode == MC_IDX && !mac.xsel) || (mac.ymode == MC_IDX && !mac.ysel);
    end
  end
  assign mac_err = mac_err_r;

  // Bus handshakes
  assign do_wr   = aw_have_r && w_have_r && (ws_r == WS_IDLE);
  assign awready = !aw_have_r && (ws_r == WS_IDLE);
  assign wready  = !w_have_r && (ws_r == WS_IDLE);
  assign bvalid  = (ws_r == WS_RESP);
  assign bresp   = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_have_r <= 1'b1;
      awaddr_r  <= awaddr;
    end else if (do_wr) begin
      aw_have_r <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (wvalid && wready) begin
      w_have_r <= 1'b1;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (do_wr) begin
      w_have_r <= 1'b0;
    end
  end

  // Write response state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_r <= WS_IDLE;
    end else begin
      case (ws_r)
        WS_IDLE: if (do_wr) ws_r <= WS_RESP;
        WS_RESP: if (bready) ws_r <= WS_IDLE;
        default: ws_r <= WS_IDLE;
      endcase
    end
  end

  // Writable register decode
  always_comb begin
    if (awaddr_r == `MAG_OFS_CTRL) wr_hit = 1'b1;
    else if (awaddr_r == `MAG_OFS_XSTART) wr_hit = 1'b1;
    else if (awaddr_r == `MAG_OFS_XEND) wr_hit = 1'b1;
    else if (awaddr_r == `MAG_OFS_YSTART) wr_hit = 1'b1;
    else if (awaddr_r == `MAG_OFS_YEND) wr_hit = 1'b1;
    else if (awaddr_r == `MAG_OFS_BREV) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  // Response code, latched with the write
  always_ff @(posedge aclk) begin
    if (!aresetn) bresp_r <= `MAG_RESP_OKAY;
    else if (do_wr) bresp_r <= wr_hit ? `MAG_RESP_OKAY : `MAG_RESP_SLVERR;
  end

  // Register file; start bit zero reads 0 and end bit zero reads 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `MAG_CTRL_RST;
      xs_r   <= `MAG_START_RST;
      xe_r   <= `MAG_END_RST;
      ys_r   <= `MAG_START_RST;
      ye_r   <= `MAG_END_RST;
      rev_r  <= `MAG_BREV_RST;
    end else if (do_wr) begin
      if (awaddr_r == `MAG_OFS_CTRL) ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r) & 16'hCFFF;
      else if (awaddr_r == `MAG_OFS_XSTART) xs_r <= merge16(xs_r, wdata_r, wstrb_r) & 16'hFFFE;
      else if (awaddr_r == `MAG_OFS_XEND) xe_r <= merge16(xe_r, wdata_r, wstrb_r) | 16'h0001;
      else if (awaddr_r == `MAG_OFS_YSTART) ys_r <= merge16(ys_r, wdata_r, wstrb_r) & 16'hFFFE;
      else if (awaddr_r == `MAG_OFS_YEND) ye_r <= merge16(ye_r, wdata_r, wstrb_r) | 16'h0001;
      else if (awaddr_r == `MAG_OFS_BREV) rev_r <= merge16(rev_r, wdata_r, wstrb_r);
    end
  end

  // Read channel; unmapped addresses answer zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `MAG_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `MAG_RESP_OKAY;
      if (araddr == `MAG_OFS_CTRL) rdata_r <= {16'h0000, ctrl_r};
      else if (araddr == `MAG_OFS_XSTART) rdata_r <= {16'h0000, xs_r};
      else if (araddr == `MAG_OFS_XEND) rdata_r <= {16'h0000, xe_r};
      else if (araddr == `MAG_OFS_YSTART) rdata_r <= {16'h0000, ys_r};
      else if (araddr == `MAG_OFS_YEND) rdata_r <= {16'h0000, ye_r};
      else if (araddr == `MAG_OFS_BREV) rdata_r <= {16'h0000, rev_r};
      else if (araddr == `MAG_OFS_STATUS) rdata_r <= {28'h000_0000, mac_err_r, brev_en, y_on, x_on};
      else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `MAG_RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_x_plain;
    rd_req.valid && !mac.valid && rd_req.mode == MD_PRE && !x_on;
  endsequence

  sequence s_mac_x_inc6;
    mac.valid && mac.xmode == MC_INC6 && !x_on;
  endsequence

  sequence s_mac_y_dec2;
    mac.valid && mac.ymode == MC_DEC2 && !y_on;
  endsequence

  sequence s_x_regofs;
    rd_req.valid && !mac.valid && rd_req.mode == MD_REGOFS && !x_on;
  endsequence

  sequence s_xw_brev;
    xw_q.valid && brev_en && xw_q.wreg == ctrl_r[`MAG_BSEL]
      && xw_q.mode == MD_POST && !xw_q.modv[15] && xw_q.word;
  endsequence

  x_plain_step_a: assert property (s_x_plain |=> xr_res.wb_val == $past(rd_req.ptr) + $past(rd_req.modv))
    else $error("X read pre-step corrected while circular is off");
  mac_route_a: assert property (mac.valid |=> xr_res.valid && y_res.valid)
    else $error("Prefetch did not reach both lanes");
  mac_idx_err_a: assert property (mac.valid && mac.xmode == MC_IDX && !mac.xsel |=> mac_err)
    else $error("Indexed prefetch through W8 not flagged");
  mac_post_six_a: assert property (s_mac_x_inc6 |=> xr_res.wb_val == $past(mac.xptr) + `MAG_STEP6)
    else $error("Prefetch post step of six wrong");
  y_plain_step_a: assert property (s_mac_y_dec2 |=> y_res.wb_en && y_res.wb_val == $past(mac.yptr) - `MAG_STEP2)
    else $error("Y step corrected while circular is off");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped before taken");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("Read not answered next cycle");
  ofs_shared_a: assert property (s_x_regofs |=> xr_res.ea == $past(rd_req.ptr) + $past(offset_reg_val))
    else $error("Indexed move read used the wrong offset");
  brev_step_a: assert property (s_xw_brev |=> xw_res.wb_en && !xw_res.wb_val[0])
    else $error("Bit-reversed write step left an odd pointer");
  mac_err_hold_a: assert property (!mac.valid |=> $stable(mac_err))
    else $error("Prefetch error flag changed without a prefetch");

endmodule // mag_top

// >>> core/mag_consts.svh
/*
  Constants of the circular address generator: register byte offsets,
  field positions, reset values and step sizes.
  Assumes inclusion by bare name from the generator's design files.
*/
`ifndef MAG_CONSTS_SVH
`define MAG_CONSTS_SVH

// Register byte offsets on the register bus
`define MAG_OFS_CTRL    8'h00
`define MAG_OFS_XSTART  8'h04
`define MAG_OFS_XEND    8'h08
`define MAG_OFS_YSTART  8'h0C
`define MAG_OFS_YEND    8'h10
`define MAG_OFS_BREV    8'h14
`define MAG_OFS_STATUS  8'h18

// Field positions in circular_addr_control and bitrev_control
`define MAG_XSEL        3:0
`define MAG_YSEL        7:4
`define MAG_BSEL        11:8
`define MAG_XEN         15
`define MAG_YEN         14
`define MAG_BITREV_ENABLE        15
`define MAG_BMOD        14:0
`define MAG_SEL_OFF     4'hF

// Reset values
`define MAG_CTRL_RST    16'h0000
`define MAG_START_RST   16'h0000
`define MAG_END_RST     16'h0001
`define MAG_BREV_RST    16'h0000

// Multiply-accumulate pointer steps
`define MAG_STEP2       16'h0002
`define MAG_STEP4       16'h0004
`define MAG_STEP6       16'h0006

// Bus response codes
`define MAG_RESP_OKAY   2'b00
`define MAG_RESP_SLVERR 2'b10

`endif

// >>> core/mag_pkg.sv
/*
  Types of the circular address generator: addressing modes, bus write
  states and the request and result carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mag_pkg;

  // Addressing mode of a move or accumulator operand
  typedef enum logic [2:0] {
    MD_IND    = 3'b000,
    MD_POST   = 3'b001,
    MD_PRE    = 3'b010,
    MD_REGOFS = 3'b011,
    MD_LITOFS = 3'b100
  } mag_mode_type;

  // Addressing mode of a multiply-accumulate prefetch
  typedef enum logic [2:0] {
    MC_IND  = 3'b000,
    MC_INC2 = 3'b001,
    MC_INC4 = 3'b010,
    MC_INC6 = 3'b011,
    MC_DEC2 = 3'b100,
    MC_DEC4 = 3'b101,
    MC_DEC6 = 3'b110,
    MC_IDX  = 3'b111
  } mag_mac_mode_type;

  // Register bus write states
  typedef enum logic {
    WS_IDLE = 1'b0,
    WS_RESP = 1'b1
  } mag_wstate_type;

  // One operand request to an address lane
  typedef struct packed {
    logic         valid;
    mag_mode_type mode;
    logic [3:0]   wreg;
    logic [15:0]  ptr;
    logic [15:0]  modv;
    logic         word;
  } mag_req_type;

  // Multiply-accumulate prefetch pair
  typedef struct packed {
    logic             valid;
    logic             xsel;
    mag_mac_mode_type xmode;
    logic [15:0]      xptr;
    logic             ysel;
    mag_mac_mode_type ymode;
    logic [15:0]      yptr;
  } mag_mac_type;

  // Registered lane result
  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [15:0] wb_val;
  } mag_res_type;

endpackage

// >>> core/mag_agu.sv
/*
  One address generator lane: pointer step, circular wrap and, where
  allowed, bit-reversed stepping, with a registered result.
  Assumes one request per cycle and a synchronous active-low reset.
*/
module mag_agu
  import mag_pkg::*;
#(
  parameter bit BREV_OK   = 1'b0,
  parameter bit WORD_ONLY = 1'b0
)(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Operand request
  input  wire mag_req_type req,
  // Circular buffer window
  input  wire logic        circ_on,
  input  wire logic [15:0] bnd_start,
  input  wire logic [15:0] bnd_end,
  // Bit-reversed stepping
  input  wire logic        brev_on,
  input  wire logic [14:0] brev_mod,
  // Registered result
  output mag_res_type      res_r
);
  logic [15:0] sum, tgt, corr, rev_sum, ea_nxt, ptr_nxt;
  logic [16:0] len;
  logic        inc, pow2, hi, lo, wrap_hit, use_brev, modify;

  // Mirror a 16-bit word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
  endfunction

  // Step, window length and boundary tests
  always_comb begin
    modify   = (req.mode == MD_PRE) || (req.mode == MD_POST);
    inc      = ~req.modv[15];
    sum      = req.ptr + req.modv;
    tgt      = (req.mode == MD_IND) ? req.ptr : sum;
    len      = {1'b0, bnd_end} - {1'b0, bnd_start} + 17'h0_0001;
    pow2     = (len & (len - 17'h0_0001)) == 17'h0_0000;
    hi       = (tgt > bnd_end) && (inc || pow2);
    lo       = (tgt < bnd_start) && (!inc || pow2);
    use_brev = BREV_OK && brev_on && modify && inc && req.word;
    wrap_hit = circ_on && !use_brev && (req.mode != MD_IND) && (hi || lo);
    rev_sum  = rev16((rev16(req.ptr) + rev16({brev_mod, 1'b0})) & 16'h7FFF);
  end

  // Wrap by one length, then pick address and new pointer
  always_comb begin
    corr = tgt;
    if (wrap_hit && hi) corr = tgt - len[15:0];
    else if (wrap_hit && lo) corr = tgt + len[15:0];
    ptr_nxt = use_brev ? rev_sum : corr;
    ea_nxt  = (req.mode == MD_POST || req.mode == MD_IND) ? req.ptr : ptr_nxt;
    if (WORD_ONLY || use_brev) ea_nxt[0] = 1'b0;
  end

  // Result register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_r <= '0;
    end else begin
      res_r.valid  <= req.valid;
      res_r.ea     <= ea_nxt;
      res_r.wb_en  <= req.valid && modify;
      res_r.wb_val <= ptr_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  y_word_ea_a: assert property (res_r.valid && WORD_ONLY |-> res_r.ea[0] == 1'b0)
    else $error("Word lane produced an odd address");
  ofs_no_wb_a: assert property (req.valid && (req.mode == MD_REGOFS || req.mode == MD_LITOFS)
    |=> res_r.valid && !res_r.wb_en)
    else $error("Offset mode asked for pointer write-back");
  wrap_inside_a: assert property (req.valid && circ_on && !use_brev && req.mode == MD_POST && inc
    && req.ptr >= bnd_start && req.ptr <= bnd_end && req.modv <= len[15:0] && len[16] == 1'b0
    |=> res_r.wb_val >= $past(bnd_start) && res_r.wb_val <= $past(bnd_end))
    else $error("Wrapped pointer left the buffer");
  brev_normal_a: assert property (req.valid && use_brev && req.mode == MD_POST
    |=> res_r.ea == ($past(req.ptr) & 16'hFFFE))
    else $error("Bit-reversed post step altered the access address");
  brev_prio_a: assert property (use_brev |-> !wrap_hit)
    else $error("Circular wrap applied during bit-reversed step");

endmodule // mag_agu

// >>> tb/mag_dec_model.sv
/*
  Decoder-side partner: drives move, offset and prefetch requests.
  Assumes the generator samples them on the shared rising clock edge.
*/
module mag_dec_model
  import mag_pkg::*;
(
  // Clock
  input  wire logic   aclk,
  // Requests towards the generator
  output mag_req_type rd_req,
  output mag_req_type wr_req,
  output logic [15:0] offset_reg_val,
  output mag_mac_type mac
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at time zero
  initial begin
    rd_req = '0;
    wr_req = '0;
    mac = '0;
    offset_reg_val = '0;
  end

  // One request cycle, then released fields scramble so stale values are never trusted
  task automatic issue(input mag_req_type r, input mag_req_type w, input mag_mac_type m,
                       input logic [15:0] ofs);
    @(posedge aclk);
    rd_req <= r;
    wr_req <= w;
    mac <= m;
    offset_reg_val <= ofs;
    @(posedge aclk);
    rd_req <= mag_req_type'({1'b0, ~r[39:0]});
    wr_req <= mag_req_type'({1'b0, ~w[39:0]});
    mac <= mag_mac_type'({1'b0, ~m[39:0]});
    offset_reg_val <= ~ofs;
  endtask
endmodule // mag_dec_model

// >>> tb/mag_top_tb.sv
/*
  Self-checking bench: register bus traffic and random lane requests
  compared with a behavioural model. Assumes the partner model above.
*/
module mag_top_tb
  import mag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, mac_err;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, r;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] ofs_val, ofs, ctrl, p1, p2, m1, m2;
  logic        xon, yon, me = 1'b0;
  logic [32:0] ex;
  mag_req_type rd_req, wr_req, rq, wq;
  mag_mac_type mac, mq;
  mag_res_type xr_res, xw_res, y_res;
  logic [31:0] seed = 32'h7030;
  int          errors = 0;
  int          samples_checked = 0;
  int          st[6] = '{2, 4, 6, -2, -4, -6};
  logic [15:0] bnd[4] = '{16'h1000, 16'h100F, 16'h2000, 16'h2009};
  logic [15:0] cfgs[3] = '{16'hC0A9, 16'hC0FF, 16'h00A9};

  mag_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rd_req(rd_req), .wr_req(wr_req),
    .offset_reg_val(ofs_val), .mac(mac), .xr_res(xr_res), .xw_res(xw_res), .y_res(y_res),
    .mac_err(mac_err));
  mag_dec_model part (.aclk(aclk), .rd_req(rd_req), .wr_req(wr_req), .offset_reg_val(ofs_val), .mac(mac));

  // Fixed-seed xorshift
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Circular correction: subtract length above end, add below start
  function automatic logic [15:0] corr(input logic [15:0] p, m, s, e, input logic on);
    int sum, len;
    logic pow2;
    sum = (int'(p) + int'($signed(m))) & 'hFFFF;
    len = int'(e) - int'(s) + 1;
    pow2 = (len & (len - 1)) == 0;
    if (on && (!m[15] || pow2) && sum > int'(e)) sum -= len;
    if (on && (m[15] || pow2) && sum < int'(s)) sum += len;
    return sum[15:0];
  endfunction

  // Expected lane result as {wb_en, wb_val, ea}
  function automatic logic [32:0] lane(input mag_mode_type md, input logic [15:0] p, m, o, s, e,
                                       input logic on, y);
    logic [15:0] n, ea;
    n = corr(p, (md == MD_REGOFS) ? o : m, s, e, on);
    ea = (md == MD_IND || md == MD_POST) ? p : n;
    if (y) ea[0] = 1'b0;
    return {md == MD_POST || md == MD_PRE, n, ea};
  endfunction

  // Prefetch modes mapped onto the move model
  function automatic logic [32:0] mlane(input mag_mac_mode_type mm, input logic w,
                                        input logic [15:0] p, o, s, e, input logic on, y);
    int k;
    mag_mode_type md;
    k = (mm == MC_IND || mm == MC_IDX) ? 0 : (mm <= MC_INC6) ? 2 * int'(mm) : -2 * (int'(mm) - 3);
    md = (mm == MC_IND) ? MD_IND : (mm == MC_IDX) ? (w ? MD_REGOFS : MD_IND) : MD_POST;
    return lane(md, p, 16'(k), o, s, e, on, y);
  endfunction

  // Reverse-carry step of a word pointer by a bit-reversed modifier
  function automatic logic [15:0] brv(input logic [15:0] p, input logic [14:0] b);
    logic [14:0] a, c, s;
    for (int i = 0; i < 15; i++) begin
      a[i] = p[15 - i];
      c[i] = b[14 - i];
    end
    a = a + c;
    for (int i = 0; i < 15; i++) s[i] = a[14 - i];
    return {s, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmp_res(input mag_res_type q, input logic [32:0] x);
    chk(32'(q.valid), 32'd1);
    chk(32'(q.ea), 32'(x[15:0]));
    chk(32'(q.wb_en), 32'(x[32]));
    if (x[32]) chk(32'(q.wb_val), 32'(x[31:16]));
  endtask

  // Register bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] re);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, v};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    re = bresp;
    bready <= 1'b0;
  endtask

  // Register bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] re);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    re = rresp;
    rready <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Hang guard
  initial begin
    repeat (6000) @(posedge aclk);
    errors++;
    conclude();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), d, rs);
      chk(d, (i == 2 || i == 4) ? 32'h0000_0001 : 32'h0000_0000);
    end
    rd(8'h40, d, rs);
    chk(d, 32'h0000_0000);
    chk(32'(rs), 32'h0000_0002);
    wr(8'h40, 16'h1234, rs);
    chk(32'(rs), 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i + 4), bnd[i], rs);
      rd(8'(4 * i + 4), d, rs);
      chk(d, 32'(bnd[i]));
    end
    foreach (cfgs[c]) begin
      ctrl = cfgs[c];
      wr(8'h00, ctrl, rs);
      rd(8'h00, d, rs);
      chk(d, 32'(ctrl));
      xon = ctrl[15] && ctrl[3:0] != 4'hF;
      yon = ctrl[14] && ctrl[7:4] != 4'hF;
      rd(8'h18, d, rs);
      chk(d, {28'h000_0000, me, 1'b0, yon, xon});
      repeat (16) begin
        r = rnd();
        p1 = {12'h100, r[11:9], 1'b0};
        p2 = {12'h100, r[22:20], 1'b0};
        m1 = 16'(st[r[15:13] % 6]);
        m2 = 16'(st[r[25:23] % 6]);
        ofs = 16'(st[r[18:16] % 6]);
        rq = '{1'b1, mag_mode_type'(r[2:0] % 5), r[6] ? 4'd9 : 4'd3, p1, m1, 1'b1};
        wq = '{1'b1, mag_mode_type'(r[5:3] % 5), r[7] ? 4'd9 : 4'd3, p2, m2, 1'b1};
        part.issue(rq, wq, '0, ofs);
        @(negedge aclk);
        cmp_res(xr_res, lane(rq.mode, p1, m1, ofs, bnd[0], bnd[1], xon && r[6], 1'b0));
        cmp_res(xw_res, lane(wq.mode, p2, m2, ofs, bnd[0], bnd[1], xon && r[7], 1'b0));
        r = rnd();
        mq = '{1'b1, r[6], mag_mac_mode_type'(r[2:0]), {12'h100, r[11:9], 1'b0}, r[7],
               mag_mac_mode_type'(r[5:3]), 16'h2000 + 16'(2 * (r[15:12] % 5))};
        mq.yptr[0] = mq.ymode == MC_IND && r[16];
        part.issue('0, '0, mq, ofs);
        @(negedge aclk);
        cmp_res(xr_res, mlane(mq.xmode, mq.xsel, mq.xptr, ofs, bnd[0], bnd[1], xon && mq.xsel, 1'b0));
        cmp_res(y_res, mlane(mq.ymode, mq.ysel, mq.yptr, ofs, bnd[2], bnd[3], yon && !mq.ysel, 1'b1));
        me = (mq.xmode == MC_IDX && !mq.xsel) || (mq.ymode == MC_IDX && !mq.ysel);
        chk(32'(mac_err), 32'(me));
      end
    end
    // Bit-reversed writes beside a circular X read on the same pointer
    wr(8'h14, 16'h8004, rs);
    rd(8'h14, d, rs);
    chk(d, 32'h0000_8004);
    wr(8'h00, 16'hC9A9, rs);
    rd(8'h18, d, rs);
    chk(d, {28'h000_0000, me, 3'b111});
    repeat (16) begin
      r = rnd();
      p1 = {12'h100, r[11:9], 1'b0};
      m1 = 16'(st[r[15:13] % 6]);
      wq = '{1'b1, r[0] ? MD_PRE : MD_POST, 4'd9, p1, m1, 1'b1};
      part.issue(wq, wq, '0, ofs);
      @(negedge aclk);
      ex = lane(wq.mode, p1, m1, ofs, bnd[0], bnd[1], 1'b1, 1'b0);
      cmp_res(xr_res, ex);
      if (!m1[15]) ex = {1'b1, brv(p1, 15'h0004), (wq.mode == MD_POST) ? p1 : brv(p1, 15'h0004)};
      cmp_res(xw_res, ex);
    end
    conclude();
  end
endmodule // mag_top_tb
